// [shared/sdi_pkg.sv]
// shared constants and types for the dram init link
package sdi_pkg;

	// ----------------------------------------------------------------
	// link command codes {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_DESEL = 4'hF;
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_MRS   = 4'h0;

	// bank select codes of the setting registers
	localparam logic [2:0] BA_PRIMARY = 3'h0;
	localparam logic [2:0] BA_EXT_ONE = 3'h1;
	localparam logic [2:0] BA_EXT_TWO = 3'h2;
	localparam logic [2:0] BA_EXT_THR = 3'h3;

	// address bit positions
	localparam int ADDR_W       = 15;
	localparam int POS_DLL_OFF  = 0;
	localparam int POS_BT       = 3;
	localparam int POS_TEST     = 7;
	localparam int POS_DLL_RST  = 8;
	localparam int POS_CAL_LO   = 7;
	localparam int POS_PRE_ALL  = 10;
	localparam int POS_A13      = 13;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] CAL_DEFAULT = 3'h7;
	localparam logic [2:0] CAL_EXIT    = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_STABLE_US   = 200;
	localparam int T_CKE_NS      = 400;
	localparam int STABLE_CYC    = T_STABLE_US * 1000000 / CLK_PERIOD_PS;
	localparam int CKE_CYC       = (T_CKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DLL_CYC       = 200;
	localparam int MRD_CYC       = 2;
	localparam int RP_CYC        = 3;
	localparam int RFC_CYC       = 26;
	localparam int REF_COUNT     = 2;
	localparam int WAIT_W        = 16;

	// ----------------------------------------------------------------
	// register map (byte offsets) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PRIM   = 8'h04;
	localparam logic [7:0] OFS_EXT1   = 8'h08;
	localparam logic [7:0] OFS_EXT2   = 8'h0C;
	localparam logic [7:0] OFS_EXT3   = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [14:0] RST_PRIM  = 15'h0432;
	localparam logic [14:0] RST_EXT1  = 15'h0000;
	localparam logic [14:0] RST_EXT2  = 15'h0000;
	localparam logic [14:0] RST_EXT3  = 15'h0000;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_STABLE  = 4'h1,
		ST_CKE     = 4'h2,
		ST_PRE1    = 4'h3,
		ST_EXT2    = 4'h4,
		ST_EXT3    = 4'h5,
		ST_EXT1    = 4'h6,
		ST_DLLRST  = 4'h7,
		ST_PRE2    = 4'h8,
		ST_REF     = 4'h9,
		ST_PRIMOP  = 4'hA,
		ST_CALWAIT = 4'hB,
		ST_CALDEF  = 4'hC,
		ST_CALEXIT = 4'hD
	} sdi_state_e;

endpackage : sdi_pkg

// [shared/sdi_link_if.sv]
// command pins between controller and dram
interface sdi_link_if;
	logic        cke;
	logic        odt;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [14:0] addr;

	modport ctrl (output cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
	modport dev  (input  cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : sdi_link_if

// [core/sdi_dram_dev.sv]
// dram end: decodes setting commands into setting registers
module sdi_dram_dev
	import sdi_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// link
	sdi_link_if.dev          link,
	// decoded settings
	output logic [3:0]       burst_len,
	output logic             burst_interleave,
	output logic [2:0]       cas_lat,
	output logic [2:0]       wr_recovery,
	output logic             test_mode,
	output logic             dll_reset_pulse,
	output logic             dll_enabled,
	output logic [2:0]       cal_ctl,
	output logic             settings_valid
);
	import sdi_pkg::*;

	logic [14:0] prim_q;
	logic [3:0]  prog_q;
	logic        is_set;

	// setting write: all strobes low while clock enable is high
	assign is_set = link.cke && ({link.cs_n, link.ras_n, link.cas_n, link.we_n} == CMD_MRS);

	// ----------------------------------------------------------------
	// primary setting register
	// ----------------------------------------------------------------
	// contents are meaningless until written, so valid stays low until all four setting registers are written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prim_q          <= 15'h0000;
			prog_q          <= 4'h0;
			dll_reset_pulse <= 1'b0;
		end else begin
			dll_reset_pulse <= 1'b0;
			if (is_set) begin
				// upper bank codes select no setting register and must not mark one written
				if (!link.ba[2]) begin
					prog_q[link.ba[1:0]] <= 1'b1;
				end
				if (link.ba == BA_PRIMARY) begin
					prim_q          <= link.addr;
					dll_reset_pulse <= link.addr[POS_DLL_RST];
				end
			end
		end
	end

	// decode happens from the stored word; no storage array is touched, so data survive re-init
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_len        <= 4'h0;
			burst_interleave <= 1'b0;
			cas_lat          <= 3'h0;
			wr_recovery      <= 3'h0;
			test_mode        <= 1'b0;
			settings_valid   <= 1'b0;
		end else begin
			case (prim_q[2:0])
				BL_CODE_4: burst_len <= 4'h4;
				BL_CODE_8: burst_len <= 4'h8;
				default:   burst_len <= 4'h0;
			endcase
			burst_interleave <= prim_q[POS_BT];
			cas_lat          <= prim_q[6:4];
			wr_recovery      <= prim_q[11:9];
			test_mode        <= prim_q[POS_TEST];
			settings_valid   <= &prog_q;
		end
	end

	// ----------------------------------------------------------------
	// extended setting register one
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dll_enabled <= 1'b0;
			cal_ctl     <= 3'h0;
		end else if (is_set && link.ba == BA_EXT_ONE) begin
			dll_enabled <= ~link.addr[POS_DLL_OFF];
			cal_ctl     <= link.addr[9:7];
		end
	end

endmodule : sdi_dram_dev

// [core/sdi_init_ctrl.sv]
// controller end: power-up sequencer with an axi4-lite register port
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
module sdi_init_ctrl
	import sdi_pkg::*;
#(
	parameter int STABLE_CYCLES = STABLE_CYC
)(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// link
	sdi_link_if.ctrl         link
);
	import sdi_pkg::*;
	sdi_state_e        state_q;
	logic [WAIT_W-1:0] wait_q;
	logic [7:0]        dll_cnt_q;
	logic [1:0]        ref_cnt_q;
	logic              booted_q, ready_q, start_q;
	logic [14:0]       prim_q, ext1_q, ext2_q, ext3_q;
	logic [3:0]        cmd_q;
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic              wr_go;
	logic [31:0]       rd_word;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	// address and data are latched independently; the write lands once both are held
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[7:2] <= OFS_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte strobes are ignored: each setting word is written whole
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prim_q  <= RST_PRIM;
			ext1_q  <= RST_EXT1;
			ext2_q  <= RST_EXT2;
			ext3_q  <= RST_EXT3;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_go) begin
				case ({awaddr_q[7:2], 2'h0})
					OFS_CTRL: start_q <= wdata_q[0];
					OFS_PRIM: prim_q  <= wdata_q[14:0];
					OFS_EXT1: ext1_q  <= wdata_q[14:0];
					OFS_EXT2: ext2_q  <= wdata_q[14:0];
					OFS_EXT3: ext3_q  <= wdata_q[14:0];
					default:  start_q <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		case ({s_axi_araddr[7:2], 2'h0})
			OFS_PRIM:   rd_word = {17'h0_0000, prim_q};
			OFS_EXT1:   rd_word = {17'h0_0000, ext1_q};
			OFS_EXT2:   rd_word = {17'h0_0000, ext2_q};
			OFS_EXT3:   rd_word = {17'h0_0000, ext3_q};
			OFS_STATUS: rd_word = {24'h00_0000, state_q, 2'h0, ready_q, state_q != ST_IDLE};
			default:    rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= (s_axi_araddr[7:2] <= OFS_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// dll settle counter
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dll_cnt_q <= 8'h00;
		end else if (state_q == ST_DLLRST && wait_q == '0) begin
			dll_cnt_q <= 8'(DLL_CYC - 1);
		end else if (dll_cnt_q != 8'h00) begin
			dll_cnt_q <= dll_cnt_q - 8'h01;
		end
	end
	// ----------------------------------------------------------------
	// init sequencer: state names the next command, issued when wait_q is zero
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_IDLE;
			wait_q    <= '0;
			ref_cnt_q <= 2'h0;
			booted_q  <= 1'b0;
			ready_q   <= 1'b0;
			cmd_q     <= CMD_DESEL;
			link.cke  <= 1'b0;
			link.odt  <= 1'b0;
			link.ba   <= 3'h0;
			link.addr <= 15'h0000;
		end else begin
			cmd_q <= link.cke ? CMD_NOP : CMD_DESEL;
			if (wait_q != '0) begin
				wait_q <= wait_q - 1'b1;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (start_q) begin
							ready_q <= 1'b0;
							// a re-init keeps the clock running, so skip the power-up wait
							state_q <= booted_q ? ST_PRE1 : ST_STABLE;
							wait_q  <= booted_q ? '0 : WAIT_W'(STABLE_CYCLES - 1);
						end
					end
					ST_STABLE: begin
						link.cke <= 1'b1;
						wait_q   <= WAIT_W'(CKE_CYC - 1);
						state_q  <= ST_PRE1;
					end
					ST_PRE1, ST_PRE2: begin
						cmd_q     <= CMD_PRE;
						link.addr <= 15'(1 << POS_PRE_ALL);
						wait_q    <= WAIT_W'(RP_CYC - 1);
						ref_cnt_q <= 2'h0;
						state_q   <= (state_q == ST_PRE1) ? ST_EXT2 : ST_REF;
					end
					ST_EXT2, ST_EXT3: begin
						cmd_q     <= CMD_MRS;
						link.ba   <= (state_q == ST_EXT2) ? BA_EXT_TWO : BA_EXT_THR;
						link.addr <= (state_q == ST_EXT2) ? ext2_q : ext3_q;
						wait_q    <= WAIT_W'(MRD_CYC - 1);
						state_q   <= (state_q == ST_EXT2) ? ST_EXT3 : ST_EXT1;
					end
					ST_EXT1: begin
						cmd_q     <= CMD_MRS;
						link.ba   <= BA_EXT_ONE;
						link.addr <= {2'h0, ext1_q[12:10], CAL_EXIT, ext1_q[6:1], 1'b0};
						wait_q    <= WAIT_W'(MRD_CYC - 1);
						state_q   <= ST_DLLRST;
					end
					ST_DLLRST, ST_PRIMOP: begin
						cmd_q     <= CMD_MRS;
						link.ba   <= BA_PRIMARY;
						// the recovery field is sent exactly as software computed it
						link.addr <= {2'h0, prim_q[12:9], (state_q == ST_DLLRST) ? 2'h2 : 2'h0,
							prim_q[6:0]};
						wait_q    <= WAIT_W'(MRD_CYC - 1);
						state_q   <= (state_q == ST_DLLRST) ? ST_PRE2 : ST_CALWAIT;
					end
					ST_REF: begin
						cmd_q     <= CMD_REF;
						wait_q    <= WAIT_W'(RFC_CYC - 1);
						ref_cnt_q <= ref_cnt_q + 2'h1;
						if (ref_cnt_q == 2'(REF_COUNT - 1)) begin
							state_q <= ST_PRIMOP;
						end
					end
					ST_CALWAIT: begin
						if (dll_cnt_q == 8'h00) begin
							state_q <= ST_CALDEF;
						end
					end
					ST_CALDEF, ST_CALEXIT: begin
						cmd_q     <= CMD_MRS;
						link.ba   <= BA_EXT_ONE;
						link.addr <= {2'h0, ext1_q[12:10], (state_q == ST_CALDEF) ? CAL_DEFAULT : CAL_EXIT,
							ext1_q[6:0]};
						wait_q    <= WAIT_W'(MRD_CYC - 1);
						state_q   <= (state_q == ST_CALDEF) ? ST_CALEXIT : ST_IDLE;
						if (state_q == ST_CALEXIT) begin
							ready_q  <= 1'b1;
							booted_q <= 1'b1;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule : sdi_init_ctrl

// [tb/sdi_link_checker.sv]
// concurrent checks on the command link between sequencer and dram
module sdi_link_checker
	import sdi_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// link
	input  wire logic        cke,
	input  wire logic        odt,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [14:0] addr
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CKE_MIN = CKE_CYC;
	localparam int DLL_MIN = DLL_CYC;
	localparam int CAL_MAX = 8;
	logic [3:0] cmd;
	logic       idle;
	logic       mrs;
	logic [3:0] last_q;
	logic [2:0] lba_q;
	logic [2:0] lcal_q;
	logic [14:0] def_q;
	logic [7:0] cke_n_q;
	logic [7:0] dll_n_q;
	assign cmd  = {cs_n, ras_n, cas_n, we_n};
	assign idle = cs_n | (cmd == CMD_NOP);
	assign mrs  = (cmd == CMD_MRS);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------------
	// history: order checks must look past the nop gaps
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_q <= CMD_DESEL;
			lba_q  <= 3'h0;
			lcal_q <= 3'h0;
		end else if (!idle) begin
			last_q <= cmd;
			lba_q  <= ba;
			lcal_q <= addr[9:7];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) def_q <= 15'h0;
		else if (mrs && ba == BA_EXT_ONE && addr[9:7] == CAL_DEFAULT) def_q <= addr;
	end
	// saturating counts; 255 is above every bound used here (80 and 200)
	always_ff @(posedge aclk) begin
		if (!aresetn || !cke) cke_n_q <= 8'h00;
		else if (cke_n_q != 8'hFF) cke_n_q <= cke_n_q + 8'h01;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) dll_n_q <= 8'h00;
		else if (mrs && ba == BA_PRIMARY && addr[8]) dll_n_q <= 8'h01;
		else if (dll_n_q != 8'hFF) dll_n_q <= dll_n_q + 8'h01;
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence cal_def_s;
		mrs && ba == BA_EXT_ONE && addr[9:7] == CAL_DEFAULT;
	endsequence
	sequence cal_exit_s;
		mrs && ba == BA_EXT_ONE && addr[9:7] == CAL_EXIT;
	endsequence
	AST_ODT_LOW: assert property (odt == 1'b0) else $error("termination driven high");
	AST_CKE_LOW_DESEL: assert property (!cke |-> cs_n) else $error("command while cke low");
	AST_CKE_WAIT: assert property (cke && !idle |-> cke_n_q >= CKE_MIN)
		else $error("command too soon after cke rise");
	AST_EXT2_ORDER: assert property (mrs && ba == BA_EXT_TWO |-> last_q == CMD_PRE)
		else $error("ext two write not after precharge");
	AST_EXT3_ORDER: assert property (mrs && ba == BA_EXT_THR |-> last_q == CMD_MRS && lba_q == BA_EXT_TWO)
		else $error("ext three write not after ext two");
	AST_DLL_EN: assert property (mrs && ba == BA_EXT_ONE && last_q == CMD_MRS && lba_q == BA_EXT_THR
		|-> !addr[0] && addr[9:7] == CAL_EXIT && addr[14:13] == 2'h0) else $error("bad dll enable word");
	AST_DLL_RST: assert property (mrs && ba == BA_PRIMARY && last_q == CMD_MRS
		|-> addr[8] && !addr[7] && addr[14:13] == 2'h0) else $error("bad dll reset word");
	AST_REF_ORDER: assert property (cmd == CMD_REF |-> last_q == CMD_PRE || last_q == CMD_REF)
		else $error("refresh out of order");
	AST_OPS_MRS: assert property (mrs && ba == BA_PRIMARY && last_q == CMD_REF |-> !addr[8] && !addr[7])
		else $error("operating word resets dll or sets test");
	AST_CAL_WAIT: assert property (cal_def_s |-> dll_n_q >= DLL_MIN) else $error("calibration too early");
	AST_CAL_PAIR: assert property (cal_def_s |-> ##[2:CAL_MAX] cal_exit_s) else $error("no calibration exit");
	AST_CAL_KEEP: assert property (cal_exit_s and (last_q == CMD_MRS && lcal_q == CAL_DEFAULT)
		|-> addr[14:10] == def_q[14:10] && addr[6:0] == def_q[6:0]) else $error("exit word lost fields");
	AST_MRS_READY: assert property (mrs |-> cke && !ba[2]) else $error("setting write while not ready");
	AST_MRS_GAP: assert property (mrs |=> idle) else $error("no gap after setting write");
endmodule : sdi_link_checker

// [tb/testbench.sv]
// self-checking bench: sequencer and dram joined by the command link
module testbench
	import sdi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 20000;
	localparam logic [14:0] EXT1V = 15'h0046;
	localparam logic [14:0] EXT2V = 15'h0080;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, cke_prev, bil, tmode, dpulse, dllen, svalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [3:0] blen;
	logic [2:0] cl, wr, cal;
	logic [17:0] mq[$];
	int miscompares, check_count, cyc, refs, pulses, cke_falls, cke_t, pre_t, dll_t, cal_t;
	sdi_link_if link_if();
	sdi_init_ctrl #(.STABLE_CYCLES(20)) u_sdi_init_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link_if));
	sdi_dram_dev u_sdi_dram_dev (.aclk(aclk), .aresetn(aresetn), .link(link_if), .burst_len(blen),
		.burst_interleave(bil), .cas_lat(cl), .wr_recovery(wr), .test_mode(tmode), .dll_reset_pulse(dpulse),
		.dll_enabled(dllen), .cal_ctl(cal), .settings_valid(svalid));
	sdi_link_checker u_chk (.aclk(aclk), .aresetn(aresetn), .cke(link_if.cke), .odt(link_if.odt),
		.cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
		.ba(link_if.ba), .addr(link_if.addr));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// link monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		cyc++;
		cke_prev <= link_if.cke;
		if (aresetn) begin
			if (link_if.cke && !cke_prev) cke_t = cyc;
			if (!link_if.cke && cke_prev) cke_falls++;
			if (!link_if.cs_n && {link_if.ras_n, link_if.cas_n, link_if.we_n} == CMD_PRE[2:0] && pre_t == 0) pre_t = cyc;
			if (!link_if.cs_n && {link_if.ras_n, link_if.cas_n, link_if.we_n} == CMD_REF[2:0]) refs++;
			if (!link_if.cs_n && {link_if.ras_n, link_if.cas_n, link_if.we_n} == CMD_MRS[2:0]) begin
				mq.push_back({link_if.ba, link_if.addr});
				if (link_if.ba == BA_PRIMARY && link_if.addr[8]) dll_t = cyc;
				if (link_if.ba == BA_EXT_ONE && link_if.addr[9:7] == CAL_DEFAULT) cal_t = cyc;
			end
			if (dpulse) pulses++;
		end
		if (cyc == LIMIT) begin
			miscompares++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// bus tasks and comparisons
	// ----------------------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_word
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		check_word({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask : wr_chk
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		axi_rd(a);
		check_word(d, e);
		check_word({30'h0, r}, {30'h0, er});
	endtask : rd_chk
	// one full start: program primary word, start, wait ready, compare link words and decode
	task automatic run_init(input logic [14:0] p);
		logic [17:0] exp[7];
		logic [3:0] bl;
		exp = '{{BA_EXT_TWO, EXT2V}, {BA_EXT_THR, 15'h0}, {BA_EXT_ONE, EXT1V}, {BA_PRIMARY, (p & 15'h1E7F) | 15'h0100},
			{BA_PRIMARY, p & 15'h1E7F}, {BA_EXT_ONE, EXT1V | 15'h0380}, {BA_EXT_ONE, EXT1V}};
		bl = (p[2:0] == BL_CODE_4) ? 4'h4 : (p[2:0] == BL_CODE_8) ? 4'h8 : 4'h0;
		mq.delete();
		refs = 0;
		wr_chk(OFS_PRIM, {17'h1FFFF, p}, RESP_OKAY);
		wr_chk(OFS_CTRL, 32'h1, RESP_OKAY);
		axi_rd(OFS_STATUS);
		check_word(d & 32'h1, 32'h1);
		do axi_rd(OFS_STATUS); while (d[1:0] !== 2'b10);
		check_word(32'(mq.size()), 32'd7);
		foreach (exp[i]) check_word({14'h0, mq[i]}, {14'h0, exp[i]});
		check_word(32'(refs), 32'd2);
		check_word({15'h0, blen, bil, cl, wr, tmode, dllen, cal, svalid}, {15'h0, bl, p[3], p[6:4], p[11:9], 5'h08, 1'b1});
	endtask : run_init
	task automatic stop_test();
		$display("check_count=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		check_word({31'h0, svalid}, 32'h0);
		rd_chk(OFS_PRIM, {17'h0, RST_PRIM}, RESP_OKAY);
		rd_chk(OFS_EXT1, 32'h0, RESP_OKAY);
		rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
		rd_chk(8'h18, 32'h0, RESP_SLVERR);
		wr_chk(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
		wr_chk(OFS_STATUS, 32'hFF, RESP_OKAY);
		rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
		wr_chk(OFS_EXT1, {17'h1FFFF, EXT1V}, RESP_OKAY);
		wr_chk(OFS_EXT2, {17'h0, EXT2V}, RESP_OKAY);
		wr_chk(OFS_EXT3, 32'h0, RESP_OKAY);
		rd_chk(OFS_EXT1, {17'h0, EXT1V}, RESP_OKAY);
		run_init(15'h0ABB);
		check_word(32'(pre_t - cke_t >= CKE_CYC), 32'h1);
		check_word(32'(cal_t - dll_t >= DLL_CYC), 32'h1);
		run_init(15'h6452);
		run_init(15'h0A30);
		check_word(32'(pulses), 32'd3);
		check_word(32'(cke_falls), 32'd0);
		stop_test();
	end
endmodule : testbench
